// File: shared/stc_pkg.sv
// Constants, register map and bus carriers for the serial transmit control block
package stc_pkg;

	// ==========================================================
	// Bus geometry
	localparam int WB_AW = 12;                          // Byte address width
	localparam int WB_DW = 32;                          // Data width

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [9:0] IDX_TSC    = 10'h11E;        // Transmit status and control
	localparam logic [9:0] IDX_TXDATA = 10'h11A;        // Transmit data / pending flag
	localparam logic [9:0] IDX_BAUD   = 10'h11B;        // Baud divisor and wide option

	// ==========================================================
	// Status and control field layout
	localparam logic [7:0] TSC_RESET = 8'h02;           // Shift-empty reads 1 at reset
	localparam logic [7:0] TSC_WMASK = 8'hFD;           // Bit 1 is read-only
	localparam int B_CLK_SRC = 7;                       // clock_source_select
	localparam int B_FRAME9  = 6;                       // frame_length_select
	localparam int B_TRANSMITTER_ENABLE    = 5;                       // transmitter_enable
	localparam int B_SYNC    = 4;                       // clocked-mode select
	localparam int B_BREAK   = 3;                       // break_request
	localparam int B_HSPEED  = 2;                       // high_speed_select
	localparam int B_EMPTY   = 1;                       // shift_empty_status
	localparam int B_NINTH   = 0;                       // ninth_data_bit
	localparam int B_WIDE    = 16;                      // wide_generator_option in baud reg
	localparam int B_PEND    = 8;                       // Pending flag in data reg

	// ==========================================================
	// Prescale counts (minus one) per baud clock
	localparam logic [5:0] SCALE_4_M1    = 6'h03;       // baudclk/4
	localparam logic [5:0] SCALE_16_M1   = 6'h0F;       // baudclk/16
	localparam logic [5:0] SCALE_64_M1   = 6'h3F;       // baudclk/64
	localparam logic [5:0] SCALE_SYNC_M1 = 6'h01;       // Half of a baudclk/4 bit

	// ==========================================================
	// Bit counts per frame kind
	localparam logic [3:0] CNT_ASYNC8 = 4'hA;           // Start, 8 data, stop
	localparam logic [3:0] CNT_ASYNC9 = 4'hB;           // Start, 9 data, stop
	localparam logic [3:0] CNT_BREAK  = 4'hE;           // Start, 12 zeros, stop
	localparam logic [3:0] CNT_SYNC8  = 4'h8;           // 8 data, no framing
	localparam logic [3:0] CNT_SYNC9  = 4'h9;           // 9 data, no framing

	// ==========================================================
	// Types
	typedef enum {TX_IDLE, TX_SHIFT} stc_tx_state_t;    // Shifter states

	typedef struct packed {
		logic               cyc;
		logic               stb;
		logic               we;
		logic [WB_AW-1:0]   adr;
		logic [3:0]         sel;
		logic [WB_DW-1:0]   dat;
	} stc_wb_req_t;                                     // Master to slave

	typedef struct packed {
		logic               ack;
		logic [WB_DW-1:0]   dat;
	} stc_wb_rsp_t;                                     // Slave to master

endpackage

// File: logic/stc_baud_gen.sv
// Baud generator: divisor stage then selectable prescale, one-cycle tick out
`timescale 1ns/1ps
module stc_baud_gen #(
	parameter int DIV_W = 16
) (
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	input  wire logic             clear,
	input  wire logic [DIV_W-1:0] divisor,
	input  wire logic [5:0]       scale_m1,
	output logic                  tick
);
	import stc_pkg::*;

	logic [DIV_W-1:0] div_cnt_r;        // Divisor stage, one baudclk per wrap
	logic [DIV_W-1:0] div_cnt_nxt;
	logic [5:0]       pre_cnt_r;        // Prescale stage
	logic [5:0]       pre_cnt_nxt;
	logic             tick_r;           // Registered tick
	logic             tick_nxt;

	assign tick = tick_r;

	// ==========================================================
	// Next count
	always_comb begin
		div_cnt_nxt = div_cnt_r + 1'b1;
		pre_cnt_nxt = pre_cnt_r;
		tick_nxt    = 1'b0;
		if (clear) begin
			// Restart one mclk ahead: the registered tick costs a cycle,
			// so the first bit of a frame is exactly one bit time long
			div_cnt_nxt = '0;
			pre_cnt_nxt = '0;
			if (divisor == '0) begin
				pre_cnt_nxt = 6'h01;
			end else begin
				div_cnt_nxt[0] = 1'b1;
			end
		end else if (div_cnt_r >= divisor) begin
			div_cnt_nxt = '0;
			if (pre_cnt_r >= scale_m1) begin
				pre_cnt_nxt = '0;
				tick_nxt    = 1'b1;
			end else begin
				pre_cnt_nxt = pre_cnt_r + 6'h01;
			end
		end
	end

	// ==========================================================
	// Count registers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			div_cnt_r <= '0;
			pre_cnt_r <= '0;
			tick_r    <= 1'b0;
		end else begin
			div_cnt_r <= div_cnt_nxt;
			pre_cnt_r <= pre_cnt_nxt;
			tick_r    <= tick_nxt;
		end
	end

	// Ticks are never adjacent, since every prescale count is at least two
	property p_tick_gap;
		@(posedge mclk) disable iff (sys_rst) tick_r && !clear |=> !tick_r;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("baud tick back to back"); // RULE6

endmodule

// File: logic/stc_serial_tx.sv
// Serial transmitter with status/control register on a classic Wishbone slave
// Notes on behaviour
// RULE1: Synchronous mode: clock source picks master/slave
// RULE2: Frame length bit picks 9 or 8 bits
// RULE3: Transmit enable bit turns transmitter on/off
// RULE4: Clocked-mode bit picks synchronous or asynchronous
// RULE5: Break request sends break, self-clears, async only
// RULE6: High-speed picks baudclk/4 or /16, else low
// RULE7: Register resets to 0x02, empty bit read-only
// RULE8: Empty bit tracks shifter; ninth bit sent
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
module stc_serial_tx #(
	parameter int DIV_W = 16
) (
	input  wire logic                mclk,
	input  wire logic                sys_rst,
	input  wire stc_pkg::stc_wb_req_t wb_req,
	output stc_pkg::stc_wb_rsp_t     wb_rsp,
	input  wire logic                bitclk_in,
	output logic                     bitclk_out,
	output logic                     bitclk_oe,
	output logic                     txd_out
);
	import stc_pkg::*;

	// ==========================================================
	// Declarations
	logic [7:0]       tsc_r;            // Control bits, bit 1 held at zero
	logic [7:0]       tsc_nxt;
	logic [7:0]       tsc_rd;           // Readback with live empty bit
	logic [7:0]       txdata_r;         // Character waiting for the shifter
	logic [7:0]       txdata_nxt;
	logic             pend_r;           // Character waiting flag
	logic             pend_nxt;
	logic [DIV_W-1:0] divisor_r;        // Baud divisor
	logic [DIV_W-1:0] divisor_nxt;
	logic             wide_r;           // wide_generator_option
	logic             wide_nxt;
	stc_wb_rsp_t      rsp_r;            // Registered bus answer
	stc_wb_rsp_t      rsp_nxt;
	logic             bus_hit;          // New request this cycle
	logic             wr_tsc;           // Write to control register
	logic [9:0]       idx;              // Word index of request

	stc_tx_state_t    state_r;          // Shifter state
	stc_tx_state_t    state_nxt;
	logic [13:0]      shreg_r;          // Outgoing bits, LSB first
	logic [13:0]      shreg_nxt;
	logic [3:0]       cnt_r;            // Bits left in frame
	logic [3:0]       cnt_nxt;
	logic             brk_frame_r;      // Current frame is a break
	logic             brk_frame_nxt;
	logic             txd_r;
	logic             txd_nxt;
	logic             clk_out_r;
	logic             clk_out_nxt;
	logic             clk_oe_r;
	logic             clk_oe_nxt;
	logic             clk_in_prev_r;    // Last sampled external bit clock
	logic             load;             // Shifter takes the pending character
	logic             brk_done;         // Break frame finished this cycle
	logic             adv;              // Move to the next bit
	logic [5:0]       scale_m1;         // Prescale for the baud generator
	logic             tick;
	logic             is_sync;
	logic             is_master;

	assign is_sync   = tsc_r[B_SYNC];
	assign is_master = tsc_r[B_CLK_SRC];

	// ==========================================================
	// Outputs straight from flops
	assign wb_rsp     = rsp_r;
	assign txd_out    = txd_r;
	assign bitclk_out = clk_out_r;
	assign bitclk_oe  = clk_oe_r;

	// ==========================================================
	// Register readback and bus decode
	assign tsc_rd  = {tsc_r[7:2], (state_r == TX_IDLE), tsc_r[0]};  // RULE8
	assign idx     = wb_req.adr[WB_AW-1:2];
	assign bus_hit = wb_req.cyc && wb_req.stb && !rsp_r.ack;
	assign wr_tsc  = bus_hit && wb_req.we && wb_req.sel[0] && (idx == IDX_TSC);

	// ==========================================================
	// Rate selection for the baud generator
	always_comb begin
		if (is_sync) begin
			scale_m1 = SCALE_SYNC_M1;               // High-speed bit ignored here RULE6
		end else if (tsc_r[B_HSPEED]) begin
			scale_m1 = wide_r ? SCALE_4_M1 : SCALE_16_M1;   // RULE6
		end else begin
			scale_m1 = wide_r ? SCALE_16_M1 : SCALE_64_M1;  // RULE6
		end
	end

	stc_baud_gen #(
		.DIV_W (DIV_W)
	) u_baud (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.clear    (load || !tsc_r[B_TRANSMITTER_ENABLE]),
		.divisor  (divisor_r),
		.scale_m1 (scale_m1),
		.tick     (tick)
	);

	// ==========================================================
	// Bus slave and register file next state
	always_comb begin
		tsc_nxt     = tsc_r;
		txdata_nxt  = txdata_r;
		pend_nxt    = pend_r;
		divisor_nxt = divisor_r;
		wide_nxt    = wide_r;
		rsp_nxt     = '0;
		// Hardware clears break once its frame is out
		if (brk_done) begin
			tsc_nxt[B_BREAK] = 1'b0;                // RULE5
		end
		if (load) begin
			pend_nxt = 1'b0;
		end
		if (bus_hit) begin
			rsp_nxt.ack = 1'b1;
			if (wb_req.we) begin
				// Later in the block so a software set beats the clear
				if (wr_tsc) begin
					tsc_nxt = wb_req.dat[7:0] & TSC_WMASK;  // RULE7
				end
				if (idx == IDX_TXDATA && wb_req.sel[0]) begin
					txdata_nxt = wb_req.dat[7:0];
					pend_nxt   = 1'b1;
				end
				if (idx == IDX_BAUD) begin
					if (wb_req.sel[0]) begin
						divisor_nxt[7:0] = wb_req.dat[7:0];
					end
					if (wb_req.sel[1]) begin
						divisor_nxt[DIV_W-1:8] = wb_req.dat[DIV_W-1:8];
					end
					if (wb_req.sel[2]) begin
						wide_nxt = wb_req.dat[B_WIDE];
					end
				end
			end else begin
				// Unmapped words read as zero
				unique case (idx)
					IDX_TSC:    rsp_nxt.dat = {24'h000000, tsc_rd};
					IDX_TXDATA: rsp_nxt.dat = {23'h000000, pend_r, txdata_r};
					IDX_BAUD:   rsp_nxt.dat = {15'h0000, wide_r, divisor_r};
					default:    rsp_nxt.dat = '0;
				endcase
			end
		end
	end

	// ==========================================================
	// Register file flops
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tsc_r     <= TSC_RESET & TSC_WMASK;     // RULE7
			txdata_r  <= '0;
			pend_r    <= 1'b0;
			divisor_r <= '0;
			wide_r    <= 1'b0;
			rsp_r     <= '0;
		end else begin
			tsc_r     <= tsc_nxt;
			txdata_r  <= txdata_nxt;
			pend_r    <= pend_nxt;
			divisor_r <= divisor_nxt;
			wide_r    <= wide_nxt;
			rsp_r     <= rsp_nxt;
		end
	end

	// ==========================================================
	// Shifter control
	assign load     = pend_r && tsc_r[B_TRANSMITTER_ENABLE] && (state_r == TX_IDLE);   // RULE3
	assign brk_done = adv && (cnt_r == 4'h1) && brk_frame_r && (state_r == TX_SHIFT);

	// Bit advance source depends on mode and clock role
	always_comb begin
		if (!is_sync) begin
			adv = tick;                             // RULE4
		end else if (is_master) begin
			adv = tick && clk_out_r;                // Falling edge of own clock RULE1
		end else begin
			adv = clk_in_prev_r && !bitclk_in;      // Far end's falling edge RULE1
		end
	end

	// ==========================================================
	// Shifter next state
	always_comb begin
		state_nxt     = state_r;
		shreg_nxt     = shreg_r;
		cnt_nxt       = cnt_r;
		brk_frame_nxt = brk_frame_r;
		txd_nxt       = txd_r;
		clk_out_nxt   = clk_out_r;
		clk_oe_nxt    = tsc_r[B_TRANSMITTER_ENABLE] && is_sync && is_master;   // RULE1
		if (!tsc_r[B_TRANSMITTER_ENABLE]) begin
			// Disabled: idle line, clock parked low
			state_nxt   = TX_IDLE;                  // RULE3
			txd_nxt     = 1'b1;
			clk_out_nxt = 1'b0;
		end else begin
			unique case (state_r)
				TX_IDLE: begin
					if (load) begin
						state_nxt = TX_SHIFT;
						brk_frame_nxt = 1'b0;
						if (is_sync) begin
							// Plain data bits, no framing RULE4
							shreg_nxt = {5'h1F, tsc_r[B_NINTH], txdata_r};   // RULE8
							cnt_nxt   = tsc_r[B_FRAME9] ? CNT_SYNC9 : CNT_SYNC8;  // RULE2
						end else if (tsc_r[B_BREAK]) begin
							// Break only counts in asynchronous mode
							shreg_nxt     = 14'h2000;   // RULE5
							cnt_nxt       = CNT_BREAK;
							brk_frame_nxt = 1'b1;
						end else if (tsc_r[B_FRAME9]) begin
							shreg_nxt = {3'h7, 1'b1, tsc_r[B_NINTH], txdata_r, 1'b0};  // RULE2
							cnt_nxt   = CNT_ASYNC9;
						end else begin
							shreg_nxt = {4'hF, 1'b1, txdata_r, 1'b0};   // RULE2
							cnt_nxt   = CNT_ASYNC8;
						end
						txd_nxt = shreg_nxt[0];
					end
				end
				TX_SHIFT: begin
					if (is_sync && is_master && tick && !clk_out_r) begin
						clk_out_nxt = 1'b1;             // Far end samples on rise
					end
					if (adv) begin
						clk_out_nxt = 1'b0;
						cnt_nxt     = cnt_r - 4'h1;
						if (cnt_r == 4'h1) begin
							state_nxt = TX_IDLE;        // RULE8
							txd_nxt   = 1'b1;
						end else begin
							shreg_nxt = {1'b1, shreg_r[13:1]};
							txd_nxt   = shreg_r[1];
						end
					end
				end
			endcase
		end
		if (!(is_sync && is_master)) begin
			clk_out_nxt = 1'b0;                     // Clock only driven as master
		end
	end

	// ==========================================================
	// Shifter flops
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_r       <= TX_IDLE;
			shreg_r       <= '1;
			cnt_r         <= '0;
			brk_frame_r   <= 1'b0;
			txd_r         <= 1'b1;
			clk_out_r     <= 1'b0;
			clk_oe_r      <= 1'b0;
			clk_in_prev_r <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			shreg_r       <= shreg_nxt;
			cnt_r         <= cnt_nxt;
			brk_frame_r   <= brk_frame_nxt;
			txd_r         <= txd_nxt;
			clk_out_r     <= clk_out_nxt;
			clk_oe_r      <= clk_oe_nxt;
			clk_in_prev_r <= bitclk_in;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	property p_slave_no_drive;
		tsc_r[B_SYNC] && !tsc_r[B_CLK_SRC] |=> !clk_oe_r && !clk_out_r;
	endproperty
	a_slave_no_drive: assert property (p_slave_no_drive) else $error("slave drives clock"); // RULE1

	property p_frame_len;
		load && !is_sync && !tsc_r[B_BREAK] |=>
			cnt_r == ($past(tsc_r[B_FRAME9]) ? CNT_ASYNC9 : CNT_ASYNC8);
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("wrong async frame length"); // RULE2

	property p_disabled;
		!tsc_r[B_TRANSMITTER_ENABLE] |=> state_r == TX_IDLE && txd_r && !clk_oe_r;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled but active"); // RULE3

	property p_async_start;
		load && !is_sync |=> !txd_r ##1 !txd_r;
	endproperty
	a_async_start: assert property (p_async_start) else $error("no start bit"); // RULE4

	property p_break_clear;
		$fell(tsc_r[B_BREAK]) && !$past(wr_tsc) |-> $past(brk_done);
	endproperty
	a_break_clear: assert property (p_break_clear) else $error("break cleared early"); // RULE5

	property p_fast_rate;
		!is_sync && tsc_r[B_HSPEED] && wide_r |-> scale_m1 == SCALE_4_M1;
	endproperty
	a_fast_rate: assert property (p_fast_rate) else $error("high speed rate wrong"); // RULE6

	property p_reset_value;
		@(posedge mclk) $fell(sys_rst) |-> tsc_rd == TSC_RESET;
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("bad reset value"); // RULE7

	property p_ninth_bit;
		load && is_sync && tsc_r[B_FRAME9] |=>
			shreg_r[8] == $past(tsc_r[B_NINTH]) && !tsc_rd[B_EMPTY];
	endproperty
	a_ninth_bit: assert property (p_ninth_bit) else $error("ninth bit lost"); // RULE8

endmodule

// File: bench/stc_rx_model.sv
// Remote serial receiver model that watches the transmit line
`timescale 1ns/1ps
module stc_rx_model (
	input  wire logic mclk,
	input  wire logic txd_out,
	input  wire logic bitclk_out,
	input  wire logic bitclk_oe,
	output logic      bitclk_in
);
	// ==========================================================
	// Slave bit clock
	// Parked low outside frames, like the block's own master clock
	initial begin
		bitclk_in = 1'b0;
	end

	// ==========================================================
	// Slave clock: raise and sample, then lower so the block moves on
	// Ends by checking that the line went back to idle high
	task automatic clk_slave(input int nb, output logic [15:0] bits, output logic ok);
		bits = '0;
		for (int i = 0; i < nb; i++) begin
			repeat (3) @(posedge mclk);
			bitclk_in <= 1'b1;
			bits[i] = txd_out;
			repeat (3) @(posedge mclk);
			bitclk_in <= 1'b0;
		end
		repeat (3) @(posedge mclk);
		ok = (txd_out === 1'b1);
	endtask

	// ==========================================================
	// Async capture: hunt the start bit, then sample mid-bit
	// Too fast or too slow a bit time shows as wrong samples
	task automatic cap_async(input int bt, input int nb, output logic [15:0] bits,
		output logic ok);
		int t;
		bits = '0;
		ok = 1'b0;
		for (t = 0; t < 400; t++) begin
			@(posedge mclk);
			if (txd_out === 1'b0) break;
		end
		if (t < 400) begin
			repeat (bt / 2 - 1) @(posedge mclk);
			for (int i = 0; i < nb; i++) begin
				bits[i] = txd_out;
				repeat (bt) @(posedge mclk);
			end
			ok = 1'b1;
		end
	endtask

	// ==========================================================
	// Sync capture: sample data on each rise of the driven clock
	task automatic cap_sync(input int nb, output logic [15:0] bits, output logic ok);
		int   n;
		logic prev;
		bits = '0;
		n = 0;
		prev = bitclk_out;
		for (int t = 0; t < 600 && n < nb; t++) begin
			@(posedge mclk);
			if (bitclk_oe === 1'b1 && bitclk_out === 1'b1 && prev === 1'b0) begin
				bits[n] = txd_out;
				n++;
			end
			prev = bitclk_out;
		end
		ok = (n == nb);
	endtask
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the serial transmit control block
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
	$display("Error at %0t ns: got %h expected %h", $time, got, exp); end end
module tb_top;
	import stc_pkg::*;

	// ==========================================================
	// Clock, reset and design wiring
	logic        mclk;                 // 20 MHz
	logic        sys_rst;              // Synchronous, active high
	stc_wb_req_t wb_req;               // Bus request
	stc_wb_rsp_t wb_rsp;               // Bus answer
	logic        bitclk_in;            // From the far end
	logic        bitclk_out;           // To the far end
	logic        bitclk_oe;            // Pin drive enable
	logic        txd_out;              // Serial line
	int          n_errors;             // Mismatches
	int          total_checks;         // Comparisons made
	logic [31:0] v;                    // Read data
	logic [15:0] bits;                 // Captured bits
	logic        ok;                   // Capture finished

	initial mclk = 1'b0;
	always #25 mclk = ~mclk;

	stc_serial_tx dut_u (
		.mclk       (mclk),
		.sys_rst    (sys_rst),
		.wb_req     (wb_req),
		.wb_rsp     (wb_rsp),
		.bitclk_in  (bitclk_in),
		.bitclk_out (bitclk_out),
		.bitclk_oe  (bitclk_oe),
		.txd_out    (txd_out)
	);

	stc_rx_model rx_u (
		.mclk       (mclk),
		.txd_out    (txd_out),
		.bitclk_out (bitclk_out),
		.bitclk_oe  (bitclk_oe),
		.bitclk_in  (bitclk_in)
	);

	// ==========================================================
	// Verdict, reached from the main flow, the bus timeout and the watchdog
	task automatic complete_run();
		$display("Checks %0d, errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Classic Wishbone cycle; answer time is never assumed
	task automatic wb(input logic we, input logic [9:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		int t;
		@(posedge mclk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'hF, dat: wd};
		for (t = 0; t < 20; t++) begin
			@(posedge mclk);
			if (wb_rsp.ack === 1'b1) break;
		end
		if (t == 20) begin
			n_errors++;
			complete_run();
		end
		rd = wb_rsp.dat;
		wb_req <= '0;
	endtask

	task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
		logic [31:0] d;
		wb(1'b1, idx, wd, d);
	endtask

	// Starts one async frame and checks the busy status on the way
	task automatic send_async(input logic [7:0] ctl, input logic wide, input int bt,
		input int nb, input logic [7:0] ch);
		logic [31:0] s;
		wr(IDX_BAUD, {15'h0000, wide, 16'h0000});
		wr(IDX_TSC, {24'h000000, ctl});
		fork
			rx_u.cap_async(bt, nb, bits, ok);
			begin
				wr(IDX_TXDATA, {24'h000000, ch});
				wb(1'b0, IDX_TSC, 32'h0, s);
				`CHK(s[B_EMPTY], 1'b0)
			end
		join
		`CHK(ok, 1'b1)
	endtask

	// ==========================================================
	// Scenarios
	task automatic sc_regs();
		wb(1'b0, IDX_TSC, 32'h0, v);
		`CHK(v, 32'h00000002)
		wr(10'h100, 32'h000000FF);
		wb(1'b0, 10'h100, 32'h0, v);
		`CHK(v, 32'h00000000)
		// Every writable bit set; break is ignored here as sync is on
		wr(IDX_TSC, 32'h000000FD);
		wb(1'b0, IDX_TSC, 32'h0, v);
		`CHK(v, 32'h000000FF)
		`CHK(bitclk_oe, 1'b1)
		wr(IDX_TSC, 32'h00000000);
		wb(1'b0, IDX_TSC, 32'h0, v);
		`CHK(v, 32'h00000002)
	endtask

	// All four speed selections; a wrong divide garbles the samples
	task automatic sc_speeds();
		logic [1:0] sel;
		int         bt;
		for (int i = 0; i < 4; i++) begin
			sel = i[1:0];
			bt = (sel == 2'h3) ? 4 : (sel == 2'h0) ? 64 : 16;
			send_async(8'h20 | {5'h00, sel[1], 2'h0}, sel[0], bt, 10, 8'hA5 ^ i[7:0]);
			`CHK(bits[9:0], {1'b1, 8'hA5 ^ i[7:0], 1'b0})
		end
	endtask

	task automatic sc_nine();
		send_async(8'h65, 1'b0, 16, 11, 8'h3C);
		`CHK(bits[10:0], {1'b1, 1'b1, 8'h3C, 1'b0})
	endtask

	task automatic sc_break();
		send_async(8'h2C, 1'b1, 4, 14, 8'h55);
		`CHK(bits[13:0], {1'b1, 13'h0000})
		repeat (4) @(posedge mclk);
		wb(1'b0, IDX_TSC, 32'h0, v);
		`CHK(v, 32'h00000026)
	endtask

	// Enable dropped mid-frame: line idles and the char is lost
	task automatic sc_abort();
		wr(IDX_TSC, 32'h00000024);
		wr(IDX_TXDATA, 32'h00000000);
		repeat (8) @(posedge mclk);
		wr(IDX_TSC, 32'h00000004);
		repeat (2) @(posedge mclk);
		`CHK(txd_out, 1'b1)
		wb(1'b0, IDX_TSC, 32'h0, v);
		`CHK(v, 32'h00000006)
		wb(1'b0, IDX_TXDATA, 32'h0, v);
		`CHK(v[B_PEND], 1'b0)
	endtask

	task automatic sc_sync();
		wr(IDX_BAUD, 32'h00000000);
		wr(IDX_TSC, 32'h000000B0);
		fork
			rx_u.cap_sync(8, bits, ok);
			wr(IDX_TXDATA, 32'h00000096);
		join
		`CHK(ok, 1'b1)
		`CHK(bits[7:0], 8'h96)
		`CHK(bitclk_oe, 1'b1)
		wr(IDX_TSC, 32'h00000030);
		repeat (2) @(posedge mclk);
		`CHK(bitclk_oe, 1'b0)
		wr(IDX_TSC, 32'h00000000);
	endtask

	// Far end clocks a 9-bit sync frame; break request must stay untouched
	task automatic sc_slave();
		wr(IDX_TSC, 32'h00000079);
		wr(IDX_TXDATA, 32'h0000005A);
		rx_u.clk_slave(9, bits, ok);
		`CHK(ok, 1'b1)
		`CHK(bits[8:0], {1'b1, 8'h5A})
		`CHK(bitclk_oe, 1'b0)
		repeat (4) @(posedge mclk);
		wb(1'b0, IDX_TSC, 32'h0, v);
		`CHK(v, 32'h0000007B)
		wr(IDX_TSC, 32'h00000000);
	endtask

	// ==========================================================
	// Main sequence with a global watchdog
	initial begin
		n_errors = 0;
		total_checks = 0;
		sys_rst = 1'b1;
		wb_req = '0;
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		sc_regs();
		sc_speeds();
		sc_nine();
		sc_break();
		sc_abort();
		sc_sync();
		sc_slave();
		complete_run();
	end

	initial begin
		repeat (90000) @(posedge mclk);
		n_errors++;
		complete_run();
	end
endmodule
